// *** core/daa_line_control_regs.sv ***
// Functional notes
// - bit 6 of first register reads 1 while a negative ring is present.
// - bit 5 of first register reads 1 while a positive ring is present.
// - bit 4 picks off-hook pin sense: 0 active low, 1 active high.
// - bit 3 enables on-hook line monitoring without going off-hook.
// - ring indicator set during ring, clears after hold time (timed from positive ring only) or off-hook.
// - bit 1 enables the off-hook pin; when 0 the pin is ignored.
// - off-hook is register bit OR enabled pin, bit independent of enable.
// - low-current mode return to on-hook skips the off-hook guard counter.
// - bit 7 of second register enables the charge pump.
// - transmit level field bits 6,1: -20, -32, mute, -26 dB.
// - receive level field bits 5,0: 0, -12, mute, -6 dB.
// - bit 4 of second register powers down the line-side chip.
// - bit 3 powers down host side; only hardware reset restores it.
// - second register resets to 0111_0000.
`default_nettype none
module daa_line_control_regs #(
	parameter longint RING_HOLD_CYCLES = daa_line_pkg::RING_CLEAR_CYCLES,
	parameter int GUARD_CYCLES = daa_line_pkg::HOOK_GUARD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic ce,
	input wire logic soft_reset,
	input wire logic [daa_line_pkg::ADDR_W-1:0] ctl_addr,
	input wire logic ctl_write,
	input wire logic [7:0] ctl_wdata,
	input wire logic ctl_read,
	output logic [7:0] ctl_rdata,
	input wire logic ring_neg_in,
	input wire logic ring_pos_in,
	input wire logic offhook_input_pin,
	input wire logic low_current_mode,
	output logic line_offhook,
	output logic line_monitor_active,
	output logic charge_pump_on,
	output logic [1:0] callprog_tx_level,
	output logic [1:0] callprog_rx_level,
	output logic tx_mute,
	output logic rx_mute,
	output logic line_side_powerdown,
	output logic host_side_powerdown
);

	// ==========================================
	// input synchronisers
	// ==========================================
	logic [1:0] neg_sync;
	logic [1:0] pos_sync;
	logic [1:0] pin_sync;
	logic ring_neg_s;
	logic ring_pos_s;
	logic pin_s;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			neg_sync <= 2'h0;
			pos_sync <= 2'h0;
			pin_sync <= 2'h0;
		end else if (ce) begin
			neg_sync <= {neg_sync[0], ring_neg_in};
			pos_sync <= {pos_sync[0], ring_pos_in};
			pin_sync <= {pin_sync[0], offhook_input_pin};
		end
	end

	assign ring_neg_s = neg_sync[1];
	assign ring_pos_s = pos_sync[1];
	assign pin_s = pin_sync[1];

	// ==========================================
	// register decode
	// ==========================================
	function automatic logic hit(input logic [daa_line_pkg::ADDR_W-1:0] a, input logic [4:0] target);
		hit = (a == target);
	endfunction

	// a powered-down host side takes no writes until hardware reset
	wire wr_ok = ce && ctl_write && !host_side_powerdown;
	wire wr_hook = wr_ok && hit(ctl_addr, daa_line_pkg::ADDR_LINE_HOOK);
	wire wr_power = wr_ok && hit(ctl_addr, daa_line_pkg::ADDR_LINE_POWER);

	// ==========================================
	// line_hook_ring_control
	// ==========================================
	logic offhook_input_polarity;
	logic onhook_line_monitor;
	logic offhook_input_enable;
	logic offhook_request;
	logic ring_indicator;

	always_ff @(posedge clk_sys) begin
		if (rst || (ce && soft_reset)) begin
			{offhook_input_polarity, onhook_line_monitor, offhook_input_enable, offhook_request}
				<= daa_line_pkg::HOOK_CTL_RESET;
		end else if (wr_hook) begin
			offhook_input_polarity <= ctl_wdata[daa_line_pkg::POLARITY_BIT];
			onhook_line_monitor <= ctl_wdata[daa_line_pkg::MONITOR_BIT];
			offhook_input_enable <= ctl_wdata[daa_line_pkg::INPUT_EN_BIT];
			offhook_request <= ctl_wdata[daa_line_pkg::REQUEST_BIT];
		end
	end

	// ==========================================
	// line_power_level_control
	// ==========================================
	logic [7:0] power_ctl;
	logic host_pd;

	always_ff @(posedge clk_sys) begin
		if (rst || (ce && soft_reset)) begin
			power_ctl <= daa_line_pkg::POWER_CTL_RESET;
		end else if (wr_power) begin
			power_ctl <= ctl_wdata & daa_line_pkg::POWER_CTL_WMASK;
		end
	end

	// soft reset deliberately leaves this bit alone: only the reset pin wakes the chip
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			host_pd <= 1'b0;
		end else if (wr_power && ctl_wdata[daa_line_pkg::HOST_PD_BIT]) begin
			host_pd <= 1'b1;
		end
	end

	assign host_side_powerdown = host_pd;
	assign charge_pump_on = power_ctl[daa_line_pkg::PUMP_BIT];
	assign callprog_tx_level = {power_ctl[daa_line_pkg::TX_HI_BIT], power_ctl[daa_line_pkg::TX_LO_BIT]};
	assign callprog_rx_level = {power_ctl[daa_line_pkg::RX_HI_BIT], power_ctl[daa_line_pkg::RX_LO_BIT]};
	assign tx_mute = (callprog_tx_level == daa_line_pkg::LEVEL_MUTE);
	assign rx_mute = (callprog_rx_level == daa_line_pkg::LEVEL_MUTE);
	assign line_side_powerdown = power_ctl[daa_line_pkg::LINE_PD_BIT];

	// ==========================================
	// off-hook control and guard counter
	// ==========================================
	logic [31:0] guard_count;
	wire pin_active = offhook_input_enable && (pin_s == offhook_input_polarity);
	wire hook_req = offhook_request || pin_active;
	wire guard_busy = (guard_count != 32'h0);
	wire hook_drop = line_offhook && !hook_req;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			guard_count <= 32'h0;
			line_offhook <= 1'b0;
		end else if (ce) begin
			line_offhook <= hook_req && !guard_busy;
			if (hook_drop && !low_current_mode) begin
				guard_count <= GUARD_CYCLES[31:0];
			end else if (hook_drop) begin
				guard_count <= 32'h0;
			end else if (guard_busy) begin
				guard_count <= guard_count - 32'h1;
			end
		end
	end

	// the monitor path only listens while the line is on-hook
	assign line_monitor_active = onhook_line_monitor && !line_offhook;

	// ==========================================
	// ring indicator and its hold timer
	// ==========================================
	logic [31:0] ring_timer;

	always_ff @(posedge clk_sys) begin
		if (rst || (ce && soft_reset)) begin
			ring_indicator <= 1'b0;
			ring_timer <= 32'h0;
		end else if (ce) begin
			if (line_offhook) begin
				ring_indicator <= 1'b0;
				ring_timer <= 32'h0;
			end else if (ring_pos_s) begin
				ring_indicator <= 1'b1;
				ring_timer <= RING_HOLD_CYCLES[31:0];
			end else if (ring_neg_s) begin
				ring_indicator <= 1'b1;
			end else if (ring_timer > 32'h1) begin
				ring_timer <= ring_timer - 32'h1;
			end else if (ring_indicator) begin
				ring_indicator <= 1'b0;
				ring_timer <= 32'h0;
			end
		end
	end

	// ==========================================
	// read-back
	// ==========================================
	wire [7:0] hook_view = {1'b0, ring_neg_s, ring_pos_s, offhook_input_polarity, onhook_line_monitor,
		ring_indicator, offhook_input_enable, offhook_request};
	wire [7:0] power_view = (power_ctl & ~(8'h01 << daa_line_pkg::HOST_PD_BIT))
		| ({7'h00, host_pd} << daa_line_pkg::HOST_PD_BIT);
	wire [7:0] next_rdata = hit(ctl_addr, daa_line_pkg::ADDR_LINE_HOOK) ? hook_view
		: hit(ctl_addr, daa_line_pkg::ADDR_LINE_POWER) ? power_view : 8'h00;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ctl_rdata <= 8'h00;
		end else if (ce && ctl_read) begin
			ctl_rdata <= next_rdata;
		end
	end

	// ==========================================
	// assertions
	// ==========================================
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence read_hook;
		ce && ctl_read && hit(ctl_addr, daa_line_pkg::ADDR_LINE_HOOK);
	endsequence

	sequence drop_low_current;
		ce && hook_drop && low_current_mode;
	endsequence

	sequence write_hook;
		ce && ctl_write && !soft_reset && !host_side_powerdown
			&& hit(ctl_addr, daa_line_pkg::ADDR_LINE_HOOK);
	endsequence

	sequence write_power_open;
		ce && ctl_write && !soft_reset && !host_side_powerdown
			&& hit(ctl_addr, daa_line_pkg::ADDR_LINE_POWER);
	endsequence

	// the host side ignores every write once it has powered itself down
	sequence write_power_shut;
		ce && ctl_write && !soft_reset && host_side_powerdown;
	endsequence

	sequence host_pd_write;
		ce && ctl_write && !host_side_powerdown && ctl_wdata[daa_line_pkg::HOST_PD_BIT]
			&& hit(ctl_addr, daa_line_pkg::ADDR_LINE_POWER);
	endsequence

	sequence read_power;
		ce && ctl_read && hit(ctl_addr, daa_line_pkg::ADDR_LINE_POWER);
	endsequence

	// ring gone and timer still running: the indicator must stay up
	sequence ring_quiet_hold;
		ce && !soft_reset && ring_indicator && !line_offhook && !ring_pos_s && !ring_neg_s
			&& ring_timer > 32'h1;
	endsequence

	sequence ring_quiet_end;
		ce && !soft_reset && ring_indicator && !line_offhook && !ring_pos_s && !ring_neg_s
			&& ring_timer <= 32'h1;
	endsequence

	a_neg_flag_read: assert property (read_hook |=> ctl_rdata[6] == $past(ring_neg_s))
		else $error("negative ring flag misread");
	a_pos_flag_read: assert property (read_hook |=> ctl_rdata[5] == $past(ring_pos_s))
		else $error("positive ring flag misread");
	a_reserved_zero: assert property (read_hook |=> !ctl_rdata[7])
		else $error("reserved bit not zero");
	a_pin_polarity: assert property (ce && offhook_input_enable && pin_s == offhook_input_polarity
		&& !guard_busy |=> line_offhook) else $error("active pin did not raise off-hook");
	a_pin_ignored: assert property (ce && !offhook_input_enable && !offhook_request |=> !line_offhook)
		else $error("disabled pin raised off-hook");
	a_bit_offhook: assert property (ce && offhook_request && !guard_busy |=> line_offhook)
		else $error("off-hook bit ignored");
	a_no_guard_lowcur: assert property (drop_low_current |=> !guard_busy)
		else $error("guard started in low-current mode");
	a_guard_normal: assert property (ce && hook_drop && !low_current_mode |=> guard_busy ##0 !line_offhook)
		else $error("guard not started on hook drop");
	a_ring_offhook: assert property (ce && line_offhook |=> !ring_indicator)
		else $error("ring indicator held while off-hook");
	a_ring_set: assert property (ce && ring_pos_s && !line_offhook |=> ring_indicator)
		else $error("ring indicator not set");
	a_host_pd_hold: assert property (host_side_powerdown |=> host_side_powerdown)
		else $error("host power-down cleared without reset");
	a_power_reset: assert property ($past(rst) |-> power_ctl == daa_line_pkg::POWER_CTL_RESET)
		else $error("second register reset value wrong");
	a_tx_mute: assert property (tx_mute == (power_ctl[daa_line_pkg::TX_HI_BIT]
		&& !power_ctl[daa_line_pkg::TX_LO_BIT])) else $error("transmit mute decode wrong");
	a_rx_mute: assert property (rx_mute == (power_ctl[daa_line_pkg::RX_HI_BIT]
		&& !power_ctl[daa_line_pkg::RX_LO_BIT])) else $error("receive mute decode wrong");
	a_power_write: assert property (write_power_open
		|=> power_ctl == ($past(ctl_wdata) & daa_line_pkg::POWER_CTL_WMASK))
		else $error("second register write did not land");
	a_power_shut: assert property (write_power_shut |=> $stable(power_ctl))
		else $error("write landed while host side powered down");
	a_hook_write: assert property (write_hook
		|=> offhook_request == $past(ctl_wdata[daa_line_pkg::REQUEST_BIT]))
		else $error("off-hook bit write did not land");
	a_enable_write: assert property (write_hook
		|=> offhook_input_enable == $past(ctl_wdata[daa_line_pkg::INPUT_EN_BIT]))
		else $error("pin enable write did not land");
	a_polarity_write: assert property (write_hook
		|=> offhook_input_polarity == $past(ctl_wdata[daa_line_pkg::POLARITY_BIT]))
		else $error("pin polarity write did not land");
	a_monitor_write: assert property (write_hook
		|=> onhook_line_monitor == $past(ctl_wdata[daa_line_pkg::MONITOR_BIT]))
		else $error("monitor bit write did not land");
	a_host_pd_set: assert property (host_pd_write |=> host_side_powerdown)
		else $error("host power-down write lost");
	a_power_reserved: assert property (read_power |=> (ctl_rdata & ~daa_line_pkg::POWER_CTL_WMASK) == 8'h00)
		else $error("second register reserved bit not zero");
	a_pd_readback: assert property (read_power
		|=> ctl_rdata[daa_line_pkg::HOST_PD_BIT] == $past(host_side_powerdown))
		else $error("host power-down misread");
	a_ring_hold: assert property (ring_quiet_hold |=> ring_indicator)
		else $error("ring indicator dropped before hold ran out");
	a_ring_clear: assert property (ring_quiet_end |=> !ring_indicator)
		else $error("ring indicator outlived its hold");
	a_guard_blocks: assert property (guard_busy |-> !line_offhook)
		else $error("line off-hook while guard running");
	a_monitor_on: assert property (onhook_line_monitor && !line_offhook |-> line_monitor_active)
		else $error("line monitor not active on-hook");
	// a low enable must hold every piece of state, counters included
	a_ce_freeze: assert property (!ce |=> $stable(power_ctl) && $stable(host_pd) && $stable(offhook_request)
		&& $stable(line_offhook) && $stable(guard_count) && $stable(ring_indicator)
		&& $stable(ring_timer) && $stable(ctl_rdata))
		else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

// *** core/daa_line_pkg.sv ***
`default_nettype none
package daa_line_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] ADDR_LINE_HOOK = 5'h05;
	localparam logic [4:0] ADDR_LINE_POWER = 5'h06;
	// line_hook_ring_control field positions
	localparam int RING_NEG_BIT = 6;
	localparam int RING_POS_BIT = 5;
	localparam int POLARITY_BIT = 4;
	localparam int MONITOR_BIT = 3;
	localparam int RING_IND_BIT = 2;
	localparam int INPUT_EN_BIT = 1;
	localparam int REQUEST_BIT = 0;
	localparam logic [3:0] HOOK_CTL_RESET = 4'h0;
	// line_power_level_control field positions
	localparam int PUMP_BIT = 7;
	localparam int TX_HI_BIT = 6;
	localparam int RX_HI_BIT = 5;
	localparam int LINE_PD_BIT = 4;
	localparam int HOST_PD_BIT = 3;
	localparam int TX_LO_BIT = 1;
	localparam int RX_LO_BIT = 0;
	localparam logic [7:0] POWER_CTL_RESET = 8'h70;
	localparam logic [7:0] POWER_CTL_WMASK = 8'hFB;
	localparam logic [1:0] LEVEL_MUTE = 2'h2;
	// ring indicator hold, least figure of its window
	localparam longint CLK_KHZ = 250000;
	localparam longint RING_CLEAR_MIN_MS = 4500;
	localparam longint RING_CLEAR_CYCLES = RING_CLEAR_MIN_MS * CLK_KHZ;
	localparam int HOOK_GUARD_CYCLES = 256;
endpackage
`default_nettype wire

// *** bench/dsp_port_model.sv ***
`default_nettype none
// ==========================================
// modem dsp side of the register port
module dsp_port_model (
	input wire logic clk_sys,
	input wire logic [7:0] ctl_rdata,
	output logic [daa_line_pkg::ADDR_W-1:0] ctl_addr,
	output logic ctl_write,
	output logic [7:0] ctl_wdata,
	output logic ctl_read
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		ctl_addr = '0;
		ctl_write = 1'b0;
		ctl_wdata = 8'h00;
		ctl_read = 1'b0;
	end
	// callers clear monitor before any off-hook request or pin use
	// line-side power-down is only released once clocks are set up
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		ctl_addr <= a;
		ctl_wdata <= d;
		ctl_write <= 1'b1;
		@(posedge clk_sys);
		ctl_write <= 1'b0;
		// stale data is inverted so nothing leans on a held bus
		ctl_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		ctl_addr <= a;
		ctl_read <= 1'b1;
		@(posedge clk_sys);
		ctl_read <= 1'b0;
		#1;
		d = ctl_rdata;
	endtask
endmodule
`default_nettype wire

// *** bench/daa_line_control_regs_bench.sv ***
`default_nettype none
`define CHK(n, e, s) chk(n, 8'(e), 8'(s))
// ==========================================
// register bank bench
module daa_line_control_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [4:0] HOOK = daa_line_pkg::ADDR_LINE_HOOK;
	localparam logic [4:0] PWR = daa_line_pkg::ADDR_LINE_POWER;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic soft_reset = 1'b0;
	logic ce = 1'b1;
	logic ring_neg_in = 1'b0;
	logic ring_pos_in = 1'b0;
	logic offhook_input_pin = 1'b1;
	logic low_current_mode = 1'b0;
	logic ctl_write, ctl_read, line_offhook, line_monitor_active, charge_pump_on, tx_mute, rx_mute;
	logic line_side_powerdown, host_side_powerdown;
	logic [daa_line_pkg::ADDR_W-1:0] ctl_addr;
	logic [7:0] ctl_wdata, ctl_rdata, v;
	logic [1:0] callprog_tx_level, callprog_rx_level;
	int num_errors = 0;
	int check_count = 0;
	int cycles = 0;
	// write value, read-back value, {tx level, rx level}
	logic [7:0] row_w [5] = '{8'h00, 8'h22, 8'h41, 8'h63, 8'h94};
	logic [7:0] row_e [5] = '{8'h00, 8'h22, 8'h41, 8'h63, 8'h90};
	logic [3:0] row_l [5] = '{4'h0, 4'h6, 4'h9, 4'hF, 4'h0};
	always #2 clk_sys = ~clk_sys;
	daa_line_control_regs #(.RING_HOLD_CYCLES(20), .GUARD_CYCLES(4)) uut (.clk_sys(clk_sys), .rst(rst),
		.ce(ce), .soft_reset(soft_reset), .ctl_addr(ctl_addr), .ctl_write(ctl_write), .ctl_wdata(ctl_wdata),
		.ctl_read(ctl_read), .ctl_rdata(ctl_rdata), .ring_neg_in(ring_neg_in), .ring_pos_in(ring_pos_in),
		.offhook_input_pin(offhook_input_pin), .low_current_mode(low_current_mode), .line_offhook(line_offhook),
		.line_monitor_active(line_monitor_active), .charge_pump_on(charge_pump_on),
		.callprog_tx_level(callprog_tx_level), .callprog_rx_level(callprog_rx_level), .tx_mute(tx_mute),
		.rx_mute(rx_mute), .line_side_powerdown(line_side_powerdown), .host_side_powerdown(host_side_powerdown));
	dsp_port_model dsp (.clk_sys(clk_sys), .ctl_rdata(ctl_rdata), .ctl_addr(ctl_addr), .ctl_write(ctl_write),
		.ctl_wdata(ctl_wdata), .ctl_read(ctl_read));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
		check_count++;
		if (s !== e) begin
			$display("BAD %s expected %h seen %h", n, e, s);
			num_errors++;
		end
	endtask
	task automatic pause(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		`CHK("rdata reset", 8'h00, ctl_rdata);
		`CHK("mutes, line pd", 8'h07, {tx_mute, rx_mute, line_side_powerdown});
		dsp.rd(PWR, v);
		`CHK("power reset", 8'h70, v);
		dsp.rd(HOOK, v);
		`CHK("hook reset", 8'h00, v);
		dsp.rd(5'h07, v);
		`CHK("unmapped", 8'h00, v);
		for (int i = 0; i < 5; i++) begin
			dsp.wr(PWR, row_w[i]);
			dsp.rd(PWR, v);
			`CHK("power reg", row_e[i], v);
			`CHK("levels", row_l[i], {callprog_tx_level, callprog_rx_level});
			`CHK("mutes", {row_l[i][3:2] == 2'b10, row_l[i][1:0] == 2'b10}, {tx_mute, rx_mute});
			`CHK("pump, pd", {row_e[i][7], row_e[i][4]}, {charge_pump_on, line_side_powerdown});
		end
		// pin low with polarity low, but not yet enabled
		@(posedge clk_sys) offhook_input_pin <= 1'b0;
		pause(5);
		`CHK("pin ignored", 1'b0, line_offhook);
		dsp.wr(HOOK, 8'h02);
		pause(4);
		`CHK("pin active low", 1'b1, line_offhook);
		@(posedge clk_sys) offhook_input_pin <= 1'b1;
		pause(5);
		`CHK("pin released", 1'b0, line_offhook);
		dsp.wr(HOOK, 8'h12);
		pause(5);
		`CHK("pin active high", 1'b1, line_offhook);
		dsp.wr(HOOK, 8'h11);
		dsp.rd(HOOK, v);
		`CHK("hook bits", 8'h11, v);
		`CHK("reg offhook", 1'b1, line_offhook);
		dsp.wr(HOOK, 8'h08);
		pause(8);
		`CHK("monitor", 8'h01, {line_offhook, line_monitor_active});
		dsp.wr(HOOK, 8'h00);
		@(posedge clk_sys) ring_pos_in <= 1'b1;
		pause(4);
		dsp.rd(HOOK, v);
		`CHK("pos ring", 8'h24, v);
		@(posedge clk_sys) ring_pos_in <= 1'b0;
		pause(8);
		dsp.rd(HOOK, v);
		`CHK("ring held", 8'h04, v);
		dsp.wr(HOOK, 8'h01);
		@(posedge clk_sys) ring_neg_in <= 1'b1;
		pause(4);
		dsp.rd(HOOK, v);
		`CHK("neg ring offhook", 8'h41, v);
		@(posedge clk_sys) ring_neg_in <= 1'b0;
		dsp.wr(HOOK, 8'h00);
		pause(8);
		@(posedge clk_sys) ring_pos_in <= 1'b1;
		pause(3);
		@(posedge clk_sys) ring_pos_in <= 1'b0;
		pause(30);
		dsp.rd(HOOK, v);
		`CHK("ring expired", 8'h00, v);
		// low-current return skips the guard, so re-hook is immediate
		@(posedge clk_sys) low_current_mode <= 1'b1;
		dsp.wr(HOOK, 8'h01);
		pause(2);
		dsp.wr(HOOK, 8'h00);
		dsp.wr(HOOK, 8'h01);
		pause(1);
		`CHK("no guard", 1'b1, line_offhook);
		@(posedge clk_sys) low_current_mode <= 1'b0;
		dsp.wr(HOOK, 8'h00);
		dsp.wr(PWR, 8'h80);
		// a write offered while the enable is low must not land
		@(posedge clk_sys) ce <= 1'b0;
		dsp.wr(PWR, 8'h63);
		ce <= 1'b1;
		dsp.rd(PWR, v);
		`CHK("ce freeze", 8'h80, v);
		@(posedge clk_sys) soft_reset <= 1'b1;
		@(posedge clk_sys) soft_reset <= 1'b0;
		dsp.rd(PWR, v);
		`CHK("soft reset", 8'h70, v);
		dsp.wr(PWR, 8'h08);
		dsp.wr(PWR, 8'h80);
		dsp.rd(PWR, v);
		`CHK("pd blocks write", 8'h08, v);
		@(posedge clk_sys) soft_reset <= 1'b1;
		@(posedge clk_sys) soft_reset <= 1'b0;
		pause(2);
		`CHK("pd survives", 1'b1, host_side_powerdown);
		@(posedge clk_sys) rst <= 1'b1;
		pause(2);
		@(posedge clk_sys) rst <= 1'b0;
		dsp.rd(PWR, v);
		`CHK("pd cleared", 8'h70, {v[7:4], host_side_powerdown, v[2:0]});
		close_out();
	end
endmodule
`default_nettype wire
